// *** design/rotate_right_nocarry.v ***
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "rotr_map.vh"
// Behaviour
// - Selected 8-bit file register is rotated right by exactly one bit.
// - Destination bit 0: result to working register, source left unchanged.
// - Destination bit 1 (default): result written back to the source register.
// - Bank access bit 0: access bank used, bank select register ignored.
// - Bank access bit 1 (default): bank select register chooses the bank.
// - Access bit 0 with extended set: file address up to 95 is indexed.
// - No carry involvement: old bit 0 goes to bit 7.
module rotate_right_nocarry
(
  // Clock and reset
  input wire mclk,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Status
  output reg busy
);
  localparam [2:0] PH_IDLE = `PH_IDLE;
  localparam [2:0] PH_DECODE = `PH_DECODE;
  localparam [2:0] PH_READ = `PH_READ;
  localparam [2:0] PH_PROC = `PH_PROC;
  localparam [2:0] PH_WRITE = `PH_WRITE;

  // Data memory: 16 banks of 256 bytes
  reg [7:0] file_mem [0:4095];
  reg [7:0] work_reg;
  reg [3:0] bank_select_reg;
  reg ext_en_reg;
  reg [7:0] fsr_reg;
  reg [9:0] cmd_reg;
  reg [2:0] phase_reg;
  reg [11:0] faddr_reg;
  reg [7:0] operand_reg;
  reg [7:0] result_reg;
  reg [11:0] mem_idx_reg;
  reg [7:0] done_cnt_reg;
  wire setup_ph = psel & ~penable;
  // Writes land only on the completing access edge, never in setup
  wire acc_done = psel & penable & pready;
  wire wr_ok = acc_done & pwrite;
  wire rd_setup = setup_ph & ~pwrite;
  // Register write strobes
  wire wr_cmd = wr_ok & (paddr == `ADDR_CMD);
  wire wr_bank = wr_ok & (paddr == `ADDR_BANK);
  wire wr_cfg = wr_ok & (paddr == `ADDR_CFG);
  wire wr_work = wr_ok & (paddr == `ADDR_WORK);
  wire wr_mem_idx = wr_ok & (paddr == `ADDR_MEM_IDX);
  wire wr_mem_data = wr_ok & (paddr == `ADDR_MEM_DATA);
  // Write data fields
  wire [9:0] cmd_wdata = pwdata[`CMD_W_MSB:`CMD_F_LSB];
  wire [3:0] bank_wdata = pwdata[`BANK_MSB:`BANK_LSB];
  wire [7:0] base_wdata = pwdata[`CFG_BASE_MSB:`CFG_BASE_LSB];
  wire [11:0] idx_wdata = pwdata[`IDX_MSB:`IDX_LSB];
  wire [7:0] byte_wdata = pwdata[`BYTE_MSB:`BYTE_LSB];
  // Instruction fields
  wire [7:0] cmd_f = cmd_reg[`CMD_F_MSB:`CMD_F_LSB];
  wire cmd_dest = cmd_reg[`CMD_D_BIT];
  wire cmd_bank_sel = cmd_reg[`CMD_A_BIT];
  // Status word: busy, completed count, phase
  wire [31:0] status_word = {13'h0, phase_reg, done_cnt_reg, 7'h0, busy};

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `ADDR_CMD) || (a == `ADDR_BANK) || (a == `ADDR_CFG) ||
                  (a == `ADDR_WORK) || (a == `ADDR_STATUS) || (a == `ADDR_MEM_IDX) ||
                  (a == `ADDR_MEM_DATA);
    end
  endfunction

  // Effective file address from f, a, bank select and extended mode
  function [11:0] eff_addr;
    input [7:0] f;
    input a;
    input ext;
    input [3:0] bank;
    input [7:0] fsr;
    reg [7:0] idx;
    begin
      // Index wraps inside the low bank
      idx = fsr + f;
      if (a)
        eff_addr = {bank, f};
      else if (ext && (f <= `IDX_LIMIT))
        eff_addr = {`ACCESS_LO_BANK, idx};
      else if (f < `ACCESS_SPLIT)
        eff_addr = {`ACCESS_LO_BANK, f};
      else
        eff_addr = {`ACCESS_HI_BANK, f};
    end
  endfunction

  // Issue is refused while busy so a half-finished write cannot be lost
  always @(posedge mclk)
  begin
    if (reset)
    begin
      phase_reg <= PH_IDLE;
      cmd_reg <= 10'h000;
      faddr_reg <= 12'h000;
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
      work_reg <= 8'h00;
      done_cnt_reg <= 8'h00;
      busy <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        PH_IDLE:
        begin
          if (wr_cmd)
          begin
            cmd_reg <= cmd_wdata;
            phase_reg <= PH_DECODE;
            busy <= 1'b1;
          end
        end
        PH_DECODE:
        begin
          faddr_reg <= eff_addr(cmd_f, cmd_bank_sel, ext_en_reg, bank_select_reg,
                                fsr_reg);
          phase_reg <= PH_READ;
        end
        PH_READ:
        begin
          operand_reg <= file_mem[faddr_reg];
          phase_reg <= PH_PROC;
        end
        PH_PROC:
        begin
          result_reg <= {operand_reg[0], operand_reg[7:1]};
          phase_reg <= PH_WRITE;
        end
        PH_WRITE:
        begin
          if (!cmd_dest)
            work_reg <= result_reg;
          done_cnt_reg <= done_cnt_reg + 8'h01;
          phase_reg <= PH_IDLE;
          busy <= 1'b0;
        end
        default:
        begin
          phase_reg <= PH_IDLE;
          busy <= 1'b0;
        end
      endcase
      // Instruction result wins over a software write to the working register
      if (wr_work && phase_reg != PH_WRITE)
        work_reg <= byte_wdata;
    end
  end

  // Software-only registers; no instruction writes them
  always @(posedge mclk)
  begin
    if (reset)
    begin
      bank_select_reg <= 4'h0;
      ext_en_reg <= 1'b0;
      fsr_reg <= 8'h00;
      mem_idx_reg <= 12'h000;
    end
    else
    begin
      if (wr_bank)
        bank_select_reg <= bank_wdata;
      if (wr_cfg)
      begin
        ext_en_reg <= pwdata[`CFG_EXT_BIT];
        fsr_reg <= base_wdata;
      end
      if (wr_mem_idx)
        mem_idx_reg <= idx_wdata;
    end
  end

  // Memory write port: instruction write-back has priority over software
  always @(posedge mclk)
  begin
    if (!reset && phase_reg == PH_WRITE && cmd_dest)
      file_mem[faddr_reg] <= result_reg;
    else if (!reset && wr_mem_data)
      file_mem[mem_idx_reg] <= byte_wdata;
  end

  // APB answer: no wait state, ready in the first access-phase cycle
  always @(posedge mclk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~is_mapped(paddr);
      prdata <= 32'h00000000;
      if (rd_setup)
      begin
        case (paddr)
          `ADDR_CMD: prdata <= {22'h0, cmd_reg};
          `ADDR_BANK: prdata <= {28'h0, bank_select_reg};
          `ADDR_CFG: prdata <= {16'h0, fsr_reg, 7'h0, ext_en_reg};
          `ADDR_WORK: prdata <= {24'h0, work_reg};
          `ADDR_STATUS: prdata <= status_word;
          `ADDR_MEM_IDX: prdata <= {20'h0, mem_idx_reg};
          `ADDR_MEM_DATA: prdata <= {24'h0, file_mem[mem_idx_reg]};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // rotate_right_nocarry

// *** design/rotr_map.vh ***
`ifndef ROTR_MAP_VH
`define ROTR_MAP_VH
// Register byte addresses
`define ADDR_CMD 12'h000
`define ADDR_BANK 12'h004
`define ADDR_CFG 12'h008
`define ADDR_WORK 12'h00c
`define ADDR_STATUS 12'h010
`define ADDR_MEM_IDX 12'h014
`define ADDR_MEM_DATA 12'h018
// Command register fields
`define CMD_F_LSB 0
`define CMD_F_MSB 7
`define CMD_D_BIT 8
`define CMD_A_BIT 9
// Config register fields
`define CFG_EXT_BIT 0
// Write data fields
`define CMD_W_MSB 9
`define BANK_LSB 0
`define BANK_MSB 3
`define CFG_BASE_LSB 8
`define CFG_BASE_MSB 15
`define IDX_LSB 0
`define IDX_MSB 11
`define BYTE_LSB 0
`define BYTE_MSB 7
// Indexed literal offset limit and access bank split
`define IDX_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hf
`define ACCESS_LO_BANK 4'h0
// Phase codes
`define PH_IDLE 3'h0
`define PH_DECODE 3'h1
`define PH_READ 3'h2
`define PH_PROC 3'h3
`define PH_WRITE 3'h4
`endif

// *** bench/rotr_chk.sv ***
`timescale 1ns/10ps
module rotr_chk
(
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("late ready");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  rdy_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_with_rdy_a: assert property (pslverr |-> pready) else $error("stray error");
  rd_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("data not zero");
  err_unmapped_a: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("no error");
  busy_start_a: assert property (psel && penable && pready && pwrite && paddr == 12'h000
    && !busy |=> busy) else $error("no start");
  busy_phases_a: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
    else $error("bad cycle length");
endmodule // rotr_chk
bind rotate_right_nocarry rotr_chk chk (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy));

// *** bench/rotate_right_nocarry_bench.sv ***
`timescale 1ns/10ps
module rotate_right_nocarry_bench;
  reg mclk = 0;
  reg reset = 1;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, busy;
  reg [31:0] rd;
  reg err;
  integer fail_count = 0;
  integer total_checks = 0;
  integer cyc = 0;
  always #2.5 mclk = ~mclk;
  rotate_right_nocarry dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  task results;
  begin
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end
  // Idle edge first so no signal is assigned twice in one step
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  end
  endtask
  task put(input [11:0] i, input [7:0] v);
  begin
    apb(1'b1, 12'h014, {20'h0, i});
    apb(1'b1, 12'h018, {24'h0, v});
  end
  endtask
  task get(input [11:0] i, input [7:0] v);
  begin
    apb(1'b1, 12'h014, {20'h0, i});
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, {24'h0, v});
  end
  endtask
  // Poll busy; a new command during busy would be dropped
  task run(input [9:0] c);
  begin
    apb(1'b1, 12'h000, {22'h0, c});
    do apb(1'b0, 12'h010, 32'h0); while (rd[0] !== 1'b0);
  end
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    put(12'h235, 8'hd7);
    apb(1'b1, 12'h004, 32'h2);
    run(10'h335);
    get(12'h235, 8'heb);
    $display("test 1 done");
    run(10'h235);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'hf5);
    get(12'h235, 8'heb);
    $display("test 2 done");
    put(12'h035, 8'h01);
    put(12'hf90, 8'h03);
    run(10'h135);
    run(10'h190);
    get(12'h035, 8'h80);
    get(12'hf90, 8'h81);
    get(12'h235, 8'heb);
    $display("test 3 done");
    apb(1'b1, 12'h008, 32'h1001);
    put(12'h06f, 8'h04);
    run(10'h15f);
    get(12'h06f, 8'h02);
    put(12'h060, 8'h10);
    run(10'h160);
    get(12'h060, 8'h08);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test 4 done");
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h00000600);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h160);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1001);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    $display("test 5 done");
    results;
  end
endmodule // rotate_right_nocarry_bench
